// ==== hdl/evi_pkg.sv ====
// Purpose: Shared constants and types for the event interrupt vectoring block.
// Assumes: Byte addresses on a 32-bit Avalon-MM register port, one word per register.
// Notes:   Source index order equals arbitration rank order for the event sources.
package evi_pkg;

    localparam int N_EVENT = 17;
    localparam int N_SOFT  = 7;
    localparam int N_SRC   = 24;
    localparam int N_PRIO  = 9;

    localparam logic [5:0] OFF_ENABLE_LOW  = 6'h00;
    localparam logic [5:0] OFF_ENABLE_HIGH = 6'h04;
    localparam logic [5:0] OFF_PRIO_A0     = 6'h08;
    localparam logic [5:0] OFF_PRIO_LAST   = 6'h28;
    localparam logic [5:0] OFF_SOFT_REQ    = 6'h2C;
    localparam logic [5:0] OFF_SOFT_EN     = 6'h30;
    localparam logic [5:0] OFF_PENDING     = 6'h34;
    localparam logic [5:0] OFF_WINNER      = 6'h38;

    localparam int GLOBAL_ENABLE_BIT = 15;
    localparam int LOW_ENABLES       = 11;
    localparam int HIGH_ENABLES      = 6;
    localparam int FIELD_W           = 3;
    localparam int SOFT_LSB          = 1;

    localparam logic [3:0]  PRIO_EVENT_BASE = 4'h8;
    localparam logic [15:0] SOFT_VECTOR_BASE = 16'h0100;
    localparam logic [4:0]  SOFT_RANK        = 5'h1F;

    localparam logic [N_EVENT-1:0] ENABLE_RESET = 17'h00000;
    localparam logic [7:0]         PRIO_RESET   = 8'h00;
    localparam logic [N_SOFT-1:0]  SOFT_RESET   = 7'h00;

    localparam logic [15:0] EVENT_VECTOR [N_EVENT] = '{
        16'h0080, 16'h0084, 16'h0088, 16'h008C, 16'h0090, 16'h0094, 16'h0098,
        16'h00A0, 16'h00A4, 16'h00A8, 16'h00AC,
        16'h00C0, 16'h00C4, 16'h00C8, 16'h00CC, 16'h00D0, 16'h00D4};

    // Registers 0 to 5 are group A, 6 to 8 are group B.
    localparam logic [3:0] EVENT_PRIO_REG [N_EVENT] = '{
        4'h0, 4'h0, 4'h1, 4'h1, 4'h2, 4'h2, 4'h3, 4'h4, 4'h4, 4'h5, 4'h5,
        4'h6, 4'h6, 4'h7, 4'h7, 4'h8, 4'h8};

    localparam logic [2:0] EVENT_PRIO_LSB [N_EVENT] = '{
        3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h0, 3'h4, 3'h0, 3'h4,
        3'h0, 3'h4, 3'h0, 3'h4, 3'h0, 3'h4};

    localparam logic [4:0] EVENT_RANK [N_EVENT] = '{
        5'h02, 5'h03, 5'h04, 5'h05, 5'h06, 5'h07, 5'h08, 5'h09, 5'h0A, 5'h0B, 5'h0C,
        5'h11, 5'h12, 5'h13, 5'h14, 5'h15, 5'h16};

    typedef struct packed {
        logic       ext0_flag;
        logic       timer0_overflow_flag;
        logic       ext1_flag;
        logic       timer1_overflow_flag;
        logic       timer2_overflow_flag;
        logic       timer2_capture_reload_flag;
        logic       pca_counter_overflow_flag;
        logic [4:0] pca_ch_match_flag;
        logic       adc_done_flag;
        logic       uart0_rx_flag;
        logic       uart0_tx_flag;
        logic       uart1_rx_flag;
        logic       uart1_tx_flag;
        logic       i2c_event_flag;
    } evi_flags_t;

    typedef struct packed {
        logic        valid;
        logic [15:0] vector;
        logic [3:0]  level;
        logic [4:0]  source;
    } evi_core_t;

    typedef struct packed {
        logic [N_EVENT-1:0]   enable;
        logic                 global_enable;
        logic [N_PRIO-1:0][7:0] prio;
        logic [N_SOFT-1:0]    soft_req;
        logic [N_SOFT-1:0]    soft_en;
        logic                 ack;
        logic [31:0]          rdata;
        evi_core_t            irq;
    } evi_state_t;

endpackage

// ==== hdl/evi_top.sv ====
// Purpose: Event and software interrupt enable, priority and vector arbitration.
// Assumes: Flags and cur_priority come from logic on clk; the core samples irq each cycle.
// Notes:   The winning vector is registered, so it trails its inputs by one enabled edge.
// Behaviour
// - External 0: vector 0080, A0 low, rank 2
// - Timer 0: vector 0084, A0 high, rank 3
// - External 1: vector 0088, A1 low, rank 4
// - Timer 1: vector 008C, A1 high, rank 5
// - Timer 2 either flag: 0090, A2 low
// - Counter array global: 0094, A2 high, rank 7
// - Converter: vector 0098, A3 low, rank 8
// - Serial 0 receive: 00A0, A4 low, rank 9
// - Serial 0 transmit: 00A4, A4 high, rank 10
// - Serial 1 receive: 00A8, A5 low, rank 11
// - Serial 1 transmit: 00AC, A5 high, rank 12
// - Channel 0: 00C0, B0 low, rank 17
// - Channel 1: 00C4, B0 high, rank 18
// - Channel 2: 00C8, B1 low, rank 19
// - Channel 3: 00CC, B1 high, rank 20
// - Channel 4: 00D0, B2 low, rank 21
// - Two-wire bus: 00D4, B2 high, rank 22
// - Software 1: vector 0100, fixed priority 1
// - Software 2 to 7: consecutive vectors, priority index
// - Field 0 disables; n gives 8 plus n
// - Equal priority: lowest rank wins
// - Global enable gates all event sources
//
// The Avalon-MM interface to the registers and the register addresses were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none

module evi_top (
    input  wire logic              clk,
    input  wire logic              rst,
    input  wire logic              ce,
    input  wire evi_pkg::evi_flags_t flags,
    input  wire logic [3:0]        cur_priority,
    input  wire logic [5:0]        address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic [3:0]        byteenable,
    output logic [31:0]            readdata,
    output logic                   waitrequest,
    output evi_pkg::evi_core_t     irq
);

    evi_pkg::evi_state_t st;
    evi_pkg::evi_state_t next_st;

    logic [evi_pkg::N_SRC-1:0]   req;
    logic [evi_pkg::N_SRC-1:0]   cand;
    logic [evi_pkg::N_SRC-1:0][3:0] level;
    logic [evi_pkg::N_SRC-1:0][4:0] rank;
    logic [evi_pkg::N_SRC-1:0][15:0] vec;
    logic [evi_pkg::N_EVENT-1:0][2:0] field;

    assign req[0] = flags.ext0_flag;
    assign req[1] = flags.timer0_overflow_flag;
    assign req[2] = flags.ext1_flag;
    assign req[3] = flags.timer1_overflow_flag;
    assign req[4] = flags.timer2_overflow_flag | flags.timer2_capture_reload_flag;
    assign req[5] = (|flags.pca_ch_match_flag) | flags.pca_counter_overflow_flag;
    assign req[6]  = flags.adc_done_flag;
    assign req[7]  = flags.uart0_rx_flag;
    assign req[8]  = flags.uart0_tx_flag;
    assign req[9]  = flags.uart1_rx_flag;
    assign req[10] = flags.uart1_tx_flag;
    assign req[15:11] = flags.pca_ch_match_flag;
    assign req[16] = flags.i2c_event_flag;
    assign req[23:17] = st.soft_req;

    genvar gi;
    generate
        for (gi = 0; gi < evi_pkg::N_EVENT; gi++) begin : g_event
            // field, vector and rank per table entry
            assign field[gi] = st.prio[evi_pkg::EVENT_PRIO_REG[gi]][evi_pkg::EVENT_PRIO_LSB[gi] +: evi_pkg::FIELD_W];
            // zero disables, else eight plus n
            assign level[gi] = (field[gi] == 3'h0) ? 4'h0 : (evi_pkg::PRIO_EVENT_BASE | {1'b0, field[gi]});
            assign rank[gi]  = evi_pkg::EVENT_RANK[gi];
            assign vec[gi]   = evi_pkg::EVENT_VECTOR[gi];
            assign cand[gi]  = req[gi] & st.enable[gi] & st.global_enable & (level[gi] > cur_priority);
        end
        for (gi = 0; gi < evi_pkg::N_SOFT; gi++) begin : g_soft
            assign level[evi_pkg::N_EVENT+gi] = 4'(gi + 1);
            assign rank[evi_pkg::N_EVENT+gi]  = evi_pkg::SOFT_RANK;
            assign vec[evi_pkg::N_EVENT+gi]   = evi_pkg::SOFT_VECTOR_BASE + 16'(gi * 4);
            assign cand[evi_pkg::N_EVENT+gi]  = req[evi_pkg::N_EVENT+gi] & st.soft_en[gi]
                                              & (level[evi_pkg::N_EVENT+gi] > cur_priority);
        end
    endgenerate

    // Reads are answered from the same mux that the write merge uses for unselected lanes.
    function automatic logic [31:0] reg_word(input evi_pkg::evi_state_t s, input logic [5:0] a,
                                             input logic [evi_pkg::N_SRC-1:0] p);
        logic [31:0] w;
        w = 32'h0000_0000;
        if (a == evi_pkg::OFF_ENABLE_LOW) begin
            w[evi_pkg::LOW_ENABLES-1:0]    = s.enable[evi_pkg::LOW_ENABLES-1:0];
            w[evi_pkg::GLOBAL_ENABLE_BIT] = s.global_enable;
        end else if (a == evi_pkg::OFF_ENABLE_HIGH) begin
            w[evi_pkg::HIGH_ENABLES-1:0] = s.enable[evi_pkg::N_EVENT-1:evi_pkg::LOW_ENABLES];
        end else if (a >= evi_pkg::OFF_PRIO_A0 && a <= evi_pkg::OFF_PRIO_LAST && a[1:0] == 2'h0) begin
            w[7:0] = s.prio[4'(a[5:2] - 4'h2)] & 8'h77;
        end else if (a == evi_pkg::OFF_SOFT_REQ) begin
            w[evi_pkg::SOFT_LSB +: evi_pkg::N_SOFT] = s.soft_req;
        end else if (a == evi_pkg::OFF_SOFT_EN) begin
            w[evi_pkg::SOFT_LSB +: evi_pkg::N_SOFT] = s.soft_en;
        end else if (a == evi_pkg::OFF_PENDING) begin
            w[evi_pkg::N_SRC-1:0] = p;
        end else if (a == evi_pkg::OFF_WINNER) begin
            w[31]   = s.irq.valid;
            w[12:8] = s.irq.source;
            w[3:0]  = s.irq.level;
        end
        return w;
    endfunction

    logic        bus_req;
    logic        bus_go;
    logic [31:0] lane_mask;
    logic [31:0] merged;

    assign bus_req = read | write;
    // One wait state: the first cycle of a request loads readdata, the second completes it.
    assign waitrequest = bus_req & ~st.ack;
    assign bus_go      = bus_req & st.ack;
    assign lane_mask   = {{8{byteenable[3]}}, {8{byteenable[2]}}, {8{byteenable[1]}}, {8{byteenable[0]}}};
    assign merged      = (reg_word(st, address, cand) & ~lane_mask) | (writedata & lane_mask);

    always_comb begin
        logic [3:0] best_level;
        logic [4:0] best_rank;
        logic [4:0] best_src;
        logic       found;
        best_level = 4'h0;
        best_rank  = 5'h1F;
        best_src   = 5'h00;
        found      = 1'b0;
        next_st    = st;
        next_st.ack = bus_req & ~st.ack;
        if (bus_req & ~st.ack) begin
            next_st.rdata = reg_word(st, address, cand);
        end
        if (write & bus_go) begin
            if (address == evi_pkg::OFF_ENABLE_LOW) begin
                next_st.enable[evi_pkg::LOW_ENABLES-1:0] = merged[evi_pkg::LOW_ENABLES-1:0];
                next_st.global_enable = merged[evi_pkg::GLOBAL_ENABLE_BIT];
            end else if (address == evi_pkg::OFF_ENABLE_HIGH) begin
                next_st.enable[evi_pkg::N_EVENT-1:evi_pkg::LOW_ENABLES] = merged[evi_pkg::HIGH_ENABLES-1:0];
            end else if (address >= evi_pkg::OFF_PRIO_A0 && address <= evi_pkg::OFF_PRIO_LAST
                         && address[1:0] == 2'h0) begin
                next_st.prio[4'(address[5:2] - 4'h2)] = merged[7:0] & 8'h77;
            end else if (address == evi_pkg::OFF_SOFT_REQ) begin
                next_st.soft_req = merged[evi_pkg::SOFT_LSB +: evi_pkg::N_SOFT];
            end else if (address == evi_pkg::OFF_SOFT_EN) begin
                next_st.soft_en = merged[evi_pkg::SOFT_LSB +: evi_pkg::N_SOFT];
            end
        end
        // higher level wins, equal level lower rank
        for (int i = 0; i < evi_pkg::N_SRC; i++) begin
            if (cand[i] && (!found || level[i] > best_level
                            || (level[i] == best_level && rank[i] < best_rank))) begin
                found      = 1'b1;
                best_level = level[i];
                best_rank  = rank[i];
                best_src   = 5'(i);
            end
        end
        // only a qualifying source is presented
        next_st.irq.valid  = found;
        next_st.irq.level  = found ? best_level : 4'h0;
        next_st.irq.source = best_src;
        next_st.irq.vector = found ? vec[best_src] : 16'h0000;
    end

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            st.enable        <= evi_pkg::ENABLE_RESET;
            st.global_enable <= 1'b0;
            st.prio          <= {evi_pkg::N_PRIO{evi_pkg::PRIO_RESET}};
            st.soft_req      <= evi_pkg::SOFT_RESET;
            st.soft_en       <= evi_pkg::SOFT_RESET;
            st.ack           <= 1'b0;
            st.rdata         <= 32'h0000_0000;
            st.irq           <= '0;
        end else if (ce) begin
            st <= next_st;
        end
    end

    assign readdata = st.rdata;
    assign irq      = st.irq;

    default clocking cb @(posedge clk); endclocking
    default disable iff (rst);

    sequence s_enable_low_write;
        ce && write && !waitrequest && address == evi_pkg::OFF_ENABLE_LOW && byteenable[1];
    endsequence

    sequence s_ext0_alone;
        ce && cand == 24'h000001;
    endsequence

    sequence s_first_rank_tie;
        ce && cand[0] && cand[1] && level[0] == level[1] && level[0] == 4'hF;
    endsequence

    a_global_write_lands: assert property (s_enable_low_write |=> st.global_enable == $past(writedata[15]))
        else $error("global enable did not follow the bus write");

    a_ext0_vector_out: assert property (s_ext0_alone |=> irq.valid && irq.vector == 16'h0080
                                        && irq.source == 5'h00)
        else $error("lone external 0 request gave the wrong vector");

    a_rank_tie_break: assert property (s_first_rank_tie |=> irq.source == 5'h00)
        else $error("equal priority tie not won by lower rank");

    a_event_level_range: assert property (irq.valid && irq.source < 5'h11 |-> irq.level >= 4'h9)
        else $error("event presented below priority nine");

    a_soft_fixed_level: assert property (irq.valid && irq.source >= 5'h11
                                         |-> irq.level == 4'(irq.source - 5'h10)
                                             && irq.vector == 16'h0100 + 16'({irq.source - 5'h11, 2'h0}))
        else $error("software interrupt level or vector wrong");

    a_above_current: assert property (ce |=> (irq.valid |-> irq.level > $past(cur_priority)))
        else $error("interrupt presented at or below current priority");

    a_global_gate_off: assert property (ce && !st.global_enable |=> !(irq.valid && irq.source < 5'h11))
        else $error("event presented with global enable clear");

    a_reset_cleared: assert property ($past(rst) |-> st.enable == 17'h00000 && st.prio == '0
                                      && st.soft_en == 7'h00 && !st.global_enable)
        else $error("enables or priorities not clear after reset");

    a_bus_one_wait: assert property (ce && bus_req && waitrequest |=> !waitrequest || !bus_req)
        else $error("bus request not answered after one wait state");

    a_freeze_on_ce: assert property (!ce |=> $stable(st))
        else $error("state moved while clock enable low");

endmodule

`default_nettype wire

// ==== tb/evi_core_model.sv ====
// Purpose: Behavioural processor core that faces the interrupt vector output.
// Assumes: The core changes its execution priority only on clk edges.
// Notes:   Priority follows the bench's command one edge late, as it would after a context switch.
`timescale 1ns/1ps
`default_nettype none

module evi_core_model (
    input  wire logic               clk,
    input  wire logic               rst,
    input  wire evi_pkg::evi_core_t irq,
    input  wire logic [3:0]         want_prio,
    output logic [3:0]              cur_priority,
    output logic [15:0]             taken_vector
);
    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            cur_priority <= 4'h0;
            taken_vector <= 16'h0000;
        end else begin
            cur_priority <= want_prio;
            if (irq.valid) begin
                taken_vector <= irq.vector;
            end
        end
    end
endmodule

`default_nettype wire

// ==== tb/tb_event_interrupt_vectoring.sv ====
// Purpose: Self-checking bench for the event interrupt vectoring block.
// Assumes: One wait state on the register port; irq trails its inputs by one edge.
// Notes:   Expected irq comes from a level and rank model kept in integers.
`timescale 1ns/1ps
`default_nettype none

module tb_event_interrupt_vectoring;
    logic                clk, rst, ce, read, write, waitrequest, glob;
    logic [5:0]          address;
    logic [31:0]         writedata, readdata, rd, seed;
    logic [3:0]          byteenable, want_prio, cur_priority;
    logic [16:0]         en;
    logic [7:1]          sreq, sen;
    evi_pkg::evi_flags_t flags;
    evi_pkg::evi_core_t  irq;
    evi_pkg::evi_core_t  held;
    logic [23:0]         pend;
    logic [15:0]         taken;
    int                  fld [17];
    int                  err_total, num_checks;
    localparam logic [7:0] VEC_LO [17] = '{8'h80, 8'h84, 8'h88, 8'h8C, 8'h90, 8'h94, 8'h98, 8'hA0, 8'hA4,
        8'hA8, 8'hAC, 8'hC0, 8'hC4, 8'hC8, 8'hCC, 8'hD0, 8'hD4};

    evi_top u_dut (.clk(clk), .rst(rst), .ce(ce), .flags(flags), .cur_priority(cur_priority),
        .address(address), .read(read), .write(write), .writedata(writedata), .byteenable(byteenable),
        .readdata(readdata), .waitrequest(waitrequest), .irq(irq));
    evi_core_model u_core (.clk(clk), .rst(rst), .irq(irq), .want_prio(want_prio),
        .cur_priority(cur_priority), .taken_vector(taken));

    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end

    function automatic logic [31:0] xs();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction

    function automatic evi_pkg::evi_core_t expect_irq();
        evi_pkg::evi_core_t e;
        logic [16:0] r;
        int lv;
        e = '0;
        pend = '0;
        r = {flags.i2c_event_flag, flags.pca_ch_match_flag, flags.uart1_tx_flag, flags.uart1_rx_flag,
            flags.uart0_tx_flag, flags.uart0_rx_flag, flags.adc_done_flag,
            flags.pca_counter_overflow_flag | (|flags.pca_ch_match_flag),
            flags.timer2_overflow_flag | flags.timer2_capture_reload_flag, flags.timer1_overflow_flag,
            flags.ext1_flag, flags.timer0_overflow_flag, flags.ext0_flag};
        for (int k = 1; k < 8; k++) begin
            pend[16 + k] = sreq[k] && sen[k] && k > want_prio;
            if (pend[16 + k]) begin
                e = {1'b1, 16'(256 + 4 * (k - 1)), 4'(k), 5'(16 + k)};
            end
        end
        // Walking down the ranks lets the lowest rank win a tie.
        for (int i = 16; i >= 0; i--) begin
            lv = 8 + fld[i];
            pend[i] = r[i] && en[i] && glob && fld[i] != 0 && lv > want_prio;
            if (pend[i] && lv >= e.level) begin
                e = {1'b1, 8'h00, VEC_LO[i], 4'(lv), 5'(i)};
            end
        end
        return e;
    endfunction

    task automatic conclude();
        $display("checks=%0d errors=%0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic cmp_word(input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e) begin
            err_total++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic cmp_irq(input evi_pkg::evi_core_t e, input evi_pkg::evi_core_t g);
        num_checks++;
        if (e.valid ? (g !== e) : (g.valid !== 1'b0)) begin
            err_total++;
            $display("mismatch t=%0t exp=%h got=%h", $time, e, g);
        end
    endtask

    task automatic bus(input logic wr, input logic [5:0] a, input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge clk);
        address <= a;
        read <= !wr;
        write <= wr;
        writedata <= d;
        byteenable <= be;
        for (n = 0; n < 16; n++) begin
            @(posedge clk);
            if (waitrequest === 1'b0) break;
        end
        rd = readdata;
        read <= 1'b0;
        write <= 1'b0;
        if (n == 16) begin
            err_total++;
            conclude();
        end
    endtask

    // Writes the shadow to all thirteen registers, or reads them back and compares.
    task automatic regs(input logic wr);
        logic [31:0] w [13];
        int j;
        foreach (w[r]) w[r] = 32'h0000_0000;
        w[0] = {16'h0000, glob, 4'h0, en[10:0]};
        w[1] = {26'h0, en[16:11]};
        for (int i = 0; i < 17; i++) begin
            j = (i < 7) ? i : i + 1;
            w[2 + j / 2] |= 32'(fld[i]) << ((j % 2) * 4);
        end
        w[11] = {24'h0, sreq, 1'b0};
        w[12] = {24'h0, sen, 1'b0};
        for (int r = 0; r < 13; r++) begin
            bus(wr, 6'(4 * r), w[r], 4'hF);
            if (!wr) cmp_word(w[r], rd);
        end
    endtask

    // The winner and pending registers are read back after every arbitration check.
    task automatic check_irq();
        evi_pkg::evi_core_t e;
        repeat (3) @(posedge clk);
        e = expect_irq();
        cmp_irq(e, irq);
        if (e.valid) begin
            cmp_word({16'h0000, e.vector}, {16'h0000, taken});
        end
        bus(1'b0, evi_pkg::OFF_WINNER, 32'h0000_0000, 4'hF);
        cmp_word({e.valid, 18'h00000, e.source, 4'h0, e.level}, rd);
        bus(1'b0, evi_pkg::OFF_PENDING, 32'h0000_0000, 4'hF);
        cmp_word({8'h00, pend}, rd);
    endtask

    task automatic clear_shadow();
        en = '0;
        glob = 1'b0;
        sreq = '0;
        sen = '0;
        foreach (fld[i]) fld[i] = 0;
    endtask

    initial begin
        seed = 32'h83f6;
        err_total = 0;
        num_checks = 0;
        {rst, ce, read, write, address, writedata, byteenable, want_prio} = {1'b1, 1'b1, 48'h0};
        flags = '0;
        clear_shadow();
        repeat (16) @(posedge clk);
        rst <= 1'b0;
        flags <= '1;
        regs(1'b0);
        check_irq();
        bus(1'b1, 6'h00, 32'hFFFF_FFFF, 4'h2);
        bus(1'b0, 6'h00, 32'h0, 4'hF);
        cmp_word(32'h0000_8700, rd);
        bus(1'b1, 6'h3C, 32'hFFFF_FFFF, 4'hF);
        bus(1'b0, 6'h3C, 32'h0, 4'hF);
        cmp_word(32'h0000_0000, rd);
        glob = 1'b1;
        for (int i = 0; i < 17; i++) begin
            en = 17'(1) << i;
            fld[i] = 1 + int'(xs() % 7);
            regs(1'b1);
            check_irq();
            fld[i] = 0;
        end
        en = 17'h00003;
        fld[0] = 7;
        fld[1] = 7;
        regs(1'b1);
        check_irq();
        fld[0] = 0;
        fld[1] = 0;
        en = '0;
        sreq = 7'h7F;
        for (int k = 1; k < 8; k++) begin
            sen = 7'(1) << (k - 1);
            regs(1'b1);
            check_irq();
            want_prio <= 4'(k);
            check_irq();
        end
        for (int n = 0; n < 150; n++) begin
            en = 17'(xs());
            glob = xs() % 4 != 0;
            sreq = 7'(xs());
            sen = 7'(xs());
            foreach (fld[i]) fld[i] = (n % 4 == 0) ? 3 : int'(xs() % 8);
            flags <= evi_pkg::evi_flags_t'(18'(xs()));
            want_prio <= 4'(xs() % 13);
            regs(1'b1);
            check_irq();
        end
        // Inputs move while the clock enable is low, so irq must keep its last value.
        held = expect_irq();
        ce <= 1'b0;
        flags <= ~flags;
        repeat (3) @(posedge clk);
        cmp_irq(held, irq);
        ce <= 1'b1;
        check_irq();
        rst <= 1'b1;
        repeat (2) @(posedge clk);
        rst <= 1'b0;
        clear_shadow();
        regs(1'b0);
        check_irq();
        conclude();
    end
endmodule

`default_nettype wire
